// ---- pkg/nvc_regs.svh ----
`ifndef NVC_REGS_SVH
`define NVC_REGS_SVH
// command sequence addresses, lower 16 bits only
`define NVC_SEQ_A0        16'h4e38
`define NVC_SEQ_A1        16'hb1c7
`define NVC_SEQ_A2        16'h83e0
`define NVC_SEQ_A3        16'h7c1f
`define NVC_SEQ_A4        16'h703f
`define NVC_SEQ_STORE     16'h8fc0
`define NVC_SEQ_RECALL    16'h4c63
`define NVC_SEQ_INH_ON    16'h8b45
`define NVC_SEQ_INH_OFF   16'h4b46
// timing, ns, at 4 ns per cycle
`define NVC_CLK_NS        4
`define NVC_STROBE_NS     48
`define NVC_STROBE_CYC    ((`NVC_STROBE_NS + `NVC_CLK_NS - 1) / `NVC_CLK_NS)
`define NVC_SETUP_NS      8
`define NVC_SETUP_CYC     ((`NVC_SETUP_NS + `NVC_CLK_NS - 1) / `NVC_CLK_NS)
`define NVC_STORE_NS      10000000
`define NVC_STORE_CYC     ((`NVC_STORE_NS + `NVC_CLK_NS - 1) / `NVC_CLK_NS)
`define NVC_RECALL_NS     20000
`define NVC_RECALL_CYC    ((`NVC_RECALL_NS + `NVC_CLK_NS - 1) / `NVC_CLK_NS)
`define NVC_RESTORE_NS    5000000
`define NVC_RESTORE_CYC   ((`NVC_RESTORE_NS + `NVC_CLK_NS - 1) / `NVC_CLK_NS)
`endif

// ---- pkg/nvc_pkg.sv ----
package nvc_pkg;
  typedef enum logic [2:0] {
    NVC_OP_READ, NVC_OP_WRITE, NVC_OP_STORE, NVC_OP_RECALL, NVC_OP_INH_ON, NVC_OP_INH_OFF
  } nvc_op_e;
  typedef enum {NVC_IDLE, NVC_SETUP, NVC_STROBE, NVC_GAP, NVC_WAIT} nvc_state_e;
endpackage

// ---- pkg/nvc_cyc_if.sv ----
`timescale 1ns/100ps
interface nvc_cyc_if;
  logic        start;
  logic        is_write;
  logic [16:0] addr;
  logic [7:0]  wdata;
  logic        done;
  logic [7:0]  rdata;
  modport ctl (output start, output is_write, output addr, output wdata, input done, input rdata);
  modport phy (input start, input is_write, input addr, input wdata, output done, output rdata);
endinterface

// ---- src/nvc_bus_cycle.sv ----
`timescale 1ns/100ps
`include "nvc_regs.svh"
// one chip-enable controlled bus cycle on the sram pins
module nvc_bus_cycle #(
  parameter int unsigned SETUP_CYC  = `NVC_SETUP_CYC,
  parameter int unsigned STROBE_CYC = `NVC_STROBE_CYC
) (
  input  wire logic        i_core_clk,
  input  wire logic        i_sys_rst,
  nvc_cyc_if.phy           cyc,
  input  wire logic [7:0]  i_data_pins,
  output logic [16:0]      o_addr,
  output logic [7:0]       o_data_pins,
  output logic             o_data_pins_oe,
  output logic             o_ce_n,
  output logic             o_we_n,
  output logic             o_oe_n
);
  typedef struct packed {
    nvc_pkg::nvc_state_e st;
    logic [7:0]  cnt;
    logic        wr;
    logic [16:0] addr;
    logic [7:0]  data;
    logic        data_oe;
    logic        ce_n;
    logic        we_n;
    logic        oe_n;
    logic        done;
    logic [7:0]  rdata;
  } nvc_phy_s;
  nvc_phy_s s_q, s_d;

  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    case (s_q.st)
      nvc_pkg::NVC_IDLE: begin
        s_d.ce_n = 1'b1;
        s_d.we_n = 1'b1;
        s_d.oe_n = 1'b1;
        if (cyc.start) begin
          s_d.wr   = cyc.is_write;
          s_d.addr = cyc.addr;
          s_d.data = cyc.wdata;
          // drive data only on writes; oe kept high to avoid contention
          s_d.data_oe = cyc.is_write;
          s_d.cnt  = 8'(SETUP_CYC);
          s_d.st   = nvc_pkg::NVC_SETUP;
        end
      end
      nvc_pkg::NVC_SETUP: begin
        if (s_q.cnt <= 8'h01) begin
          // reads keep we high, oe low: both needed for a command step
          s_d.ce_n = 1'b0;
          s_d.we_n = ~s_q.wr;
          s_d.oe_n = s_q.wr;
          s_d.cnt  = 8'(STROBE_CYC);
          s_d.st   = nvc_pkg::NVC_STROBE;
        end else begin
          s_d.cnt = s_q.cnt - 8'h01;
        end
      end
      nvc_pkg::NVC_STROBE: begin
        if (s_q.cnt <= 8'h01) begin
          // chip enable ends the cycle; data sampled while still valid
          s_d.ce_n  = 1'b1;
          s_d.we_n  = 1'b1;
          s_d.oe_n  = 1'b1;
          s_d.rdata = s_q.wr ? s_q.rdata : i_data_pins;
          s_d.st    = nvc_pkg::NVC_GAP;
        end else begin
          s_d.cnt = s_q.cnt - 8'h01;
        end
      end
      nvc_pkg::NVC_GAP: begin
        s_d.data_oe = 1'b0;
        s_d.done  = 1'b1;
        s_d.st    = nvc_pkg::NVC_IDLE;
      end
      default: s_d.st = nvc_pkg::NVC_IDLE;
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      s_q <= '{st: nvc_pkg::NVC_IDLE, cnt: 8'h00, wr: 1'b0, addr: 17'h00000, data: 8'h00, data_oe: 1'b0,
               ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, done: 1'b0, rdata: 8'h00};
    end else begin
      s_q <= s_d;
    end
  end

  assign o_addr         = s_q.addr;
  assign o_data_pins    = s_q.data;
  assign o_data_pins_oe = s_q.data_oe;
  assign o_ce_n         = s_q.ce_n;
  assign o_we_n         = s_q.we_n;
  assign o_oe_n         = s_q.oe_n;
  assign cyc.done       = s_q.done;
  assign cyc.rdata      = s_q.rdata;

  AST_WE_NOT_WITH_OE: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    !(s_q.we_n == 1'b0 && s_q.oe_n == 1'b0)) else $error("write and output enable low together");
  AST_DRIVE_ONLY_WRITE: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (s_q.data_oe && !s_q.ce_n) |-> !s_q.we_n) else $error("data driven outside a write strobe");
endmodule // nvc_bus_cycle

// ---- src/nvc_host.sv ----
`timescale 1ns/100ps
`include "nvc_regs.svh"
module nvc_host #(
  parameter int unsigned STORE_CYC   = `NVC_STORE_CYC,
  parameter int unsigned RECALL_CYC  = `NVC_RECALL_CYC,
  parameter int unsigned RESTORE_CYC = `NVC_RESTORE_CYC
) (
  input  wire logic        i_core_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_req,
  input  wire nvc_pkg::nvc_op_e i_op,
  input  wire logic [16:0] i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_pwr_fail,
  input  wire logic [7:0]  i_data_pins,
  output logic             o_busy,
  output logic             o_done,
  output logic             o_refused,
  output logic [7:0]       o_rdata,
  output logic             o_inhibit_sent,
  output logic [16:0]      o_addr,
  output logic [7:0]       o_data_pins,
  output logic             o_data_pins_oe,
  output logic             o_ce_n,
  output logic             o_we_n,
  output logic             o_oe_n
);
  nvc_cyc_if cyc ();

  typedef struct packed {
    nvc_pkg::nvc_state_e st;
    nvc_pkg::nvc_op_e    op;
    logic        cmd;
    logic [2:0]  step;
    logic [15:0] last;
    logic [23:0] wait_cnt;
    logic        pf_prev;
    logic        busy;
    logic        done;
    logic        refused;
    logic [7:0]  rdata;
    logic        inh;
    logic        start;
    logic        is_write;
    logic [16:0] addr;
    logic [7:0]  wdata;
  } nvc_host_s;
  nvc_host_s s_q, s_d;

  // prefix address by step; msb forced low
  function automatic logic [16:0] prefix_addr(input logic [2:0] step);
    case (step)
      3'h0:    prefix_addr = {1'b0, `NVC_SEQ_A0};
      3'h1:    prefix_addr = {1'b0, `NVC_SEQ_A1};
      3'h2:    prefix_addr = {1'b0, `NVC_SEQ_A2};
      3'h3:    prefix_addr = {1'b0, `NVC_SEQ_A3};
      default: prefix_addr = {1'b0, `NVC_SEQ_A4};
    endcase
  endfunction

  function automatic logic [15:0] final_addr(input nvc_pkg::nvc_op_e op);
    case (op)
      nvc_pkg::NVC_OP_STORE:  final_addr = `NVC_SEQ_STORE;
      nvc_pkg::NVC_OP_RECALL: final_addr = `NVC_SEQ_RECALL;
      nvc_pkg::NVC_OP_INH_ON: final_addr = `NVC_SEQ_INH_ON;
      default:                final_addr = `NVC_SEQ_INH_OFF;
    endcase
  endfunction

  always_comb begin
    s_d = s_q;
    s_d.done    = 1'b0;
    s_d.refused = 1'b0;
    s_d.start   = 1'b0;
    s_d.pf_prev = i_pwr_fail;
    case (s_q.st)
      nvc_pkg::NVC_IDLE: begin
        s_d.busy = 1'b0;
        if (s_q.pf_prev && !i_pwr_fail) begin
          s_d.wait_cnt = 24'(RESTORE_CYC);
          s_d.busy     = 1'b1;
          s_d.st       = nvc_pkg::NVC_WAIT;
        end else if (i_req) begin
          s_d.op = i_op;
          if (i_pwr_fail && i_op != nvc_pkg::NVC_OP_READ) begin
            s_d.refused = 1'b1;
            s_d.done    = 1'b1;
          end else begin
            s_d.busy     = 1'b1;
            s_d.start    = 1'b1;
            s_d.step     = 3'h0;
            s_d.is_write = (i_op == nvc_pkg::NVC_OP_WRITE);
            s_d.wdata    = i_wdata;
            s_d.cmd      = (i_op != nvc_pkg::NVC_OP_READ) && (i_op != nvc_pkg::NVC_OP_WRITE);
            s_d.addr     = s_d.cmd ? prefix_addr(3'h0) : i_addr;
            s_d.last     = final_addr(i_op);
            s_d.st       = nvc_pkg::NVC_STROBE;
          end
        end
      end
      nvc_pkg::NVC_STROBE: begin
        if (cyc.done) begin
          s_d.rdata = cyc.rdata;
          if (s_q.cmd && s_q.step < 3'h5) begin
            s_d.step  = s_q.step + 3'h1;
            s_d.addr  = (s_q.step == 3'h4) ? {1'b0, s_q.last} : prefix_addr(s_q.step + 3'h1);
            s_d.start = 1'b1;
          end else if (s_q.cmd) begin
            s_d.st = nvc_pkg::NVC_WAIT;
            s_d.wait_cnt = (s_q.op == nvc_pkg::NVC_OP_STORE) ? 24'(STORE_CYC) :
                           (s_q.op == nvc_pkg::NVC_OP_RECALL) ? 24'(RECALL_CYC) : 24'h000001;
            if (s_q.op == nvc_pkg::NVC_OP_INH_ON) s_d.inh = 1'b1;
            if (s_q.op == nvc_pkg::NVC_OP_INH_OFF) s_d.inh = 1'b0;
          end else begin
            s_d.done = 1'b1;
            s_d.busy = 1'b0;
            s_d.st   = nvc_pkg::NVC_IDLE;
          end
        end
      end
      nvc_pkg::NVC_WAIT: begin
        if (s_q.wait_cnt <= 24'h000001) begin
          s_d.done = 1'b1;
          s_d.busy = 1'b0;
          s_d.st   = nvc_pkg::NVC_IDLE;
        end else begin
          s_d.wait_cnt = s_q.wait_cnt - 24'h000001;
        end
      end
      default: s_d.st = nvc_pkg::NVC_IDLE;
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      s_q <= '{st: nvc_pkg::NVC_IDLE, op: nvc_pkg::NVC_OP_READ, cmd: 1'b0, step: 3'h0, last: 16'h0000,
               wait_cnt: 24'h000000, pf_prev: 1'b0, busy: 1'b0, done: 1'b0, refused: 1'b0, rdata: 8'h00,
               inh: 1'b0, start: 1'b0, is_write: 1'b0, addr: 17'h00000, wdata: 8'h00};
    end else begin
      s_q <= s_d;
    end
  end

  assign cyc.start    = s_q.start;
  assign cyc.is_write = s_q.is_write;
  assign cyc.addr     = s_q.addr;
  assign cyc.wdata    = s_q.wdata;

  nvc_bus_cycle nvc_bus_cycle_inst (
    .i_core_clk     (i_core_clk),
    .i_sys_rst      (i_sys_rst),
    .cyc            (cyc.phy),
    .i_data_pins    (i_data_pins),
    .o_addr         (o_addr),
    .o_data_pins    (o_data_pins),
    .o_data_pins_oe (o_data_pins_oe),
    .o_ce_n         (o_ce_n),
    .o_we_n         (o_we_n),
    .o_oe_n         (o_oe_n)
  );

  assign o_busy         = s_q.busy;
  assign o_done         = s_q.done;
  assign o_refused      = s_q.refused;
  assign o_rdata        = s_q.rdata;
  assign o_inhibit_sent = s_q.inh;

  AST_CMD_WE_HIGH: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (s_q.cmd && s_q.st == nvc_pkg::NVC_STROBE) |-> o_we_n) else $error("write strobe in command");
  AST_CMD_MSB_ZERO: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (s_q.cmd && !o_ce_n) |-> !o_addr[16]) else $error("command address msb set");
  AST_PF_REFUSE: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (s_q.st == nvc_pkg::NVC_IDLE && i_req && i_pwr_fail && i_op != nvc_pkg::NVC_OP_READ)
    |=> o_refused) else $error("request not refused under power fail");
  AST_WAIT_QUIET: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (s_q.st == nvc_pkg::NVC_WAIT) |-> (o_ce_n && !o_data_pins_oe)) else $error("bus active during wait");
  AST_SEQ_END: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (s_q.cmd && s_q.step == 3'h5 && cyc.done && s_q.st == nvc_pkg::NVC_STROBE) |=> s_q.st == nvc_pkg::NVC_WAIT)
    else $error("sequence did not enter wait");
  AST_CMD_OE_LOW: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (s_q.cmd && !o_ce_n) |-> !o_oe_n) else $error("oe high in command read");
  AST_WR_END: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    $rose(o_we_n) |-> o_ce_n) else $error("write end without chip enable rise");
  AST_RESTORE: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (s_q.st == nvc_pkg::NVC_IDLE && s_q.pf_prev && !i_pwr_fail) |=> (o_busy && s_q.st == nvc_pkg::NVC_WAIT))
    else $error("no restore wait after power return");
endmodule // nvc_host

// ---- tb/nvc_sram_model.sv ----
`timescale 1ns/100ps
`include "nvc_regs.svh"
module nvc_sram_model #(
  parameter int unsigned BUSY_NS = 40
) (
  input  wire logic [16:0] i_addr,
  input  wire logic [7:0]  i_data_pins,
  input  wire logic        i_ce_n,
  input  wire logic        i_we_n,
  input  wire logic        i_oe_n,
  input  wire logic        i_pwr_fail,
  output logic [7:0]       o_data_pins
);
  localparam logic [15:0] PFX [5] = '{`NVC_SEQ_A0, `NVC_SEQ_A1, `NVC_SEQ_A2, `NVC_SEQ_A3, `NVC_SEQ_A4};
  logic [7:0] sram [int];
  logic [7:0] nvm  [int];
  logic [7:0] last = 8'h00;
  logic       written = 1'b0;
  logic       inhibit = 1'b0;
  logic       busy = 1'b0;
  int         step = 0;
  // unknown strobes count as idle, so reset gives no false access end
  wire        rd_act = (i_ce_n === 1'b0) && (i_oe_n === 1'b0) && (i_we_n === 1'b1);
  wire        wr_act = (i_ce_n === 1'b0) && (i_we_n === 1'b0);

  // ********
  // behaviour
  // ********
  // busy ignores input
  task automatic hold();
    busy = 1'b1;
    busy <= #BUSY_NS 1'b0;
  endtask

  task automatic do_recall();
    sram = nvm;
    written = 1'b0;
    hold();
  endtask

  always @* begin
    if (rd_act && !busy)
      last = sram.exists(int'(i_addr)) ? sram[int'(i_addr)] : ~i_addr[7:0];
    // released bus shows the inverse so stale data never passes
    o_data_pins = (rd_act && !busy) ? last : ~last;
  end

  always @(negedge wr_act) begin
    if (!busy && !i_pwr_fail && !$isunknown({i_ce_n, i_we_n, i_addr})) begin
      sram[int'(i_addr)] = i_data_pins;
      written = 1'b1;
      step = 0;
    end
  end

  always @(negedge rd_act) begin
    if (!busy && !$isunknown({i_ce_n, i_addr})) begin
      if (step < 5)
        step = (i_addr[15:0] == PFX[step]) ? step + 1 : ((i_addr[15:0] == PFX[0]) ? 1 : 0);
      else begin
        step = 0;
        case (i_addr[15:0])
          `NVC_SEQ_STORE: begin
            nvm = sram;
            written = 1'b0;
            hold();
          end
          `NVC_SEQ_RECALL: do_recall();
          `NVC_SEQ_INH_ON: inhibit = 1'b1;
          `NVC_SEQ_INH_OFF: inhibit = 1'b0;
          default: step = (i_addr[15:0] == PFX[0]) ? 1 : 0;
        endcase
      end
    end
  end

  always @(posedge i_pwr_fail) begin
    if (written && !inhibit) begin
      nvm = sram;
      written = 1'b0;
    end
  end

  always @(negedge i_pwr_fail) do_recall();
endmodule // nvc_sram_model

// ---- tb/nvc_host_tb_top.sv ----
`timescale 1ns/100ps
module nvc_host_tb_top;
  typedef struct {nvc_pkg::nvc_op_e op; logic [16:0] a; logic [7:0] d; logic [7:0] r; logic inh;} nvc_row_s;
  localparam nvc_pkg::nvc_op_e RD = nvc_pkg::NVC_OP_READ;
  localparam nvc_pkg::nvc_op_e WR = nvc_pkg::NVC_OP_WRITE;
  localparam nvc_pkg::nvc_op_e ST = nvc_pkg::NVC_OP_STORE;
  localparam nvc_pkg::nvc_op_e RC = nvc_pkg::NVC_OP_RECALL;
  logic             clk, rst, req, pf, busy, done, refd, inh, hoe, ce_n, we_n, oe_n, got_ref;
  nvc_pkg::nvc_op_e op;
  logic [16:0]      addr, pin_addr;
  logic [7:0]       wd, rdata, hd, dd, got;
  wire  [7:0]       bus = hoe ? hd : dd;
  int               n_errors = 0;
  int               compares = 0;
  // ********
  // ordinary cases
  // ********
  nvc_row_s rows [11] = '{
    '{WR, 17'h00010, 8'ha5, 8'h00, 1'b0}, '{WR, 17'h10010, 8'h3c, 8'h00, 1'b0},
    '{RD, 17'h00010, 8'h00, 8'ha5, 1'b0}, '{RD, 17'h10010, 8'h00, 8'h3c, 1'b0},
    '{ST, 17'h00000, 8'h00, 8'h00, 1'b0}, '{WR, 17'h00010, 8'h77, 8'h00, 1'b0},
    '{RD, 17'h00010, 8'h00, 8'h77, 1'b0}, '{RC, 17'h00000, 8'h00, 8'h00, 1'b0},
    '{RD, 17'h00010, 8'h00, 8'ha5, 1'b0}, '{nvc_pkg::NVC_OP_INH_ON, 17'h0, 8'h0, 8'h0, 1'b1},
    '{WR, 17'h00030, 8'h11, 8'h00, 1'b1}};

  nvc_host #(.STORE_CYC(20), .RECALL_CYC(20), .RESTORE_CYC(20)) nvc_host_inst (
    .i_core_clk(clk), .i_sys_rst(rst), .i_req(req), .i_op(op), .i_addr(addr), .i_wdata(wd),
    .i_pwr_fail(pf), .i_data_pins(bus), .o_busy(busy), .o_done(done), .o_refused(refd),
    .o_rdata(rdata), .o_inhibit_sent(inh), .o_addr(pin_addr), .o_data_pins(hd),
    .o_data_pins_oe(hoe), .o_ce_n(ce_n), .o_we_n(we_n), .o_oe_n(oe_n));
  nvc_sram_model #(.BUSY_NS(40)) nvc_sram_model_inst (
    .i_addr(pin_addr), .i_data_pins(bus), .i_ce_n(ce_n), .i_we_n(we_n), .i_oe_n(oe_n),
    .i_pwr_fail(pf), .o_data_pins(dd));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic report_and_stop();
    if (n_errors == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask

  task automatic chk1(input string n, input logic e, input logic g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s exp %b got %b", n, e, g);
    end
  endtask

  task automatic do_op(input nvc_pkg::nvc_op_e o, input logic [16:0] a, input logic [7:0] d);
    int k;
    @(posedge clk);
    req <= 1'b1;
    op <= o;
    addr <= a;
    wd <= d;
    @(posedge clk);
    req <= 1'b0;
    for (k = 0; k < 400; k++) begin
      #1;
      if (done === 1'b1) break;
      @(posedge clk);
    end
    got = rdata;
    got_ref = refd;
    chk1("done", 1'b1, done);
  endtask

  // supply change; on power return, check busy and wait out the restore
  task automatic pwr(input logic v);
    int k;
    @(posedge clk);
    pf <= v;
    repeat (3) @(posedge clk);
    #1;
    if (!v) chk1("restore_busy", 1'b1, busy);
    for (k = 0; k < 100 && busy !== 1'b0; k++) @(posedge clk);
  endtask

  initial begin
    #100000;
    n_errors++;
    report_and_stop();
  end

  initial begin
    rst = 1'b1;
    req = 1'b0;
    pf = 1'b0;
    op = RD;
    addr = 17'h00000;
    wd = 8'h00;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk8("idle_pins", 8'h07, {5'h00, ce_n, we_n, oe_n});
    chk1("idle_oe", 1'b0, hoe);
    foreach (rows[i]) begin
      do_op(rows[i].op, rows[i].a, rows[i].d);
      if (rows[i].op == RD) chk8("rdata", rows[i].r, got);
      chk1("refused", 1'b0, got_ref);
      chk1("inhibit", rows[i].inh, inh);
    end
    // ********
    // awkward cases
    // ********
    pwr(1'b1);
    do_op(WR, 17'h00030, 8'hee);
    chk1("wr_refused", 1'b1, got_ref);
    do_op(ST, 17'h00000, 8'h00);
    chk1("st_refused", 1'b1, got_ref);
    do_op(RD, 17'h00030, 8'h00);
    chk8("pf_read", 8'h11, got);
    pwr(1'b0);
    do_op(RD, 17'h00030, 8'h00);
    chk8("inh_read", 8'hcf, got);
    do_op(nvc_pkg::NVC_OP_INH_OFF, 17'h00000, 8'h00);
    chk1("inhibit_off", 1'b0, inh);
    do_op(WR, 17'h00030, 8'h22);
    pwr(1'b1);
    pwr(1'b0);
    do_op(RD, 17'h00030, 8'h00);
    chk8("save_read", 8'h22, got);
    // mid-run reset: pins idle, then the first request is taken
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk8("rst_pins", 8'h07, {5'h00, ce_n, we_n, oe_n});
    chk1("rst_busy", 1'b0, busy);
    chk1("rst_oe", 1'b0, hoe);
    do_op(RD, 17'h00030, 8'h00);
    chk8("rst_read", 8'h22, got);
    report_and_stop();
  end
endmodule // nvc_host_tb_top
